// [hw/dsf_pkg.sv]
// Package of constants and carrier types for the diagnostic status flag logic
// How it works
// RULE1 - Flag is open-drain, low reports fault
// RULE2 - On: short, overtemp, lockout, limit fault flag
// RULE3 - Off: only lockout by default
// RULE4 - Off open load needs full blanking time
// RULE5 - Request rising edge starts blanking timer
// RULE6 - No blanking start before switch-off timeout
// RULE7 - Comparator high beyond blanking sets open load
// RULE8 - Open load reported only with request high
// RULE9 - Limit fault shown on only with request low
// RULE10 - Request rise clears limit flag after delay
// RULE11 - Lasting overvoltage stops stage, flags, auto restarts
// RULE12 - Overtemp on stops stage, flags, auto restarts
// RULE13 - Absolute limit or gradient means overtemperature
// RULE14 - Off with request: open load, short, overtemp
// RULE15 - Host alternates pull-up and pull-down networks
// RULE16 - Off open load or short clears immediately
// RULE17 - Off without request: only lockout shown
// RULE18 - Delays are parameterised counters, flag released after reset
// RULE19 - Limit current above short threshold is fault
package dsf_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int OPEN_LOAD_BLANK_TIME_US = 100;
    localparam int SWITCH_OFF_TIMEOUT_US = 100;
    localparam int FLAG_CLEAR_DELAY_US = 100;
    localparam int OVERVOLTAGE_BLANK_TIME_US = 10;
    localparam int OPEN_LOAD_BLANK_CYC = OPEN_LOAD_BLANK_TIME_US * (CLK_HZ / 1_000_000);
    localparam int SWITCH_OFF_TIMEOUT_CYC = SWITCH_OFF_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int FLAG_CLEAR_DELAY_CYC = FLAG_CLEAR_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int OVERVOLTAGE_BLANK_CYC = OVERVOLTAGE_BLANK_TIME_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Carrier of the analog detector levels
    // ------------------------------------------------------------
    typedef struct packed {
        logic ground_short;
        logic temp_absolute;
        logic temp_gradient;
        logic supply_overvoltage;
        logic limit_set_short;
        logic open_load_condition;
        logic output_short_supply;
    } dsf_detect_t;

    // Off-state open-load sequencer
    typedef enum logic [1:0] {
        OL_IDLE = 2'b00,
        OL_TIMEOUT = 2'b01,
        OL_COUNT = 2'b11,
        OL_SET = 2'b10
    } dsf_ol_state_t;

endpackage : dsf_pkg

// [hw/dsf_sync.sv]
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module dsf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end

    assign q_o = s2_q;
endmodule : dsf_sync

// [hw/dsf_timer.sv]
// Count-up qualifier: done after the input has held for LIMIT cycles
`timescale 1ns/1ps
module dsf_timer #(
    parameter int W = 16,
    parameter int LIMIT = 5000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Control
    input wire logic run_i,
    output logic done_o
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Restart whenever run drops, saturate at the limit
    always_comb begin
        cnt_d = cnt_q;
        if (!run_i) begin
            cnt_d = '0;
        end else if (cnt_q != W'(LIMIT)) begin
            cnt_d = cnt_q + W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done_o = run_i && (cnt_q == W'(LIMIT));
endmodule : dsf_timer

// [hw/dsf_flag.sv]
// Top: status flag logic of a single-channel high-side switch
`timescale 1ns/1ps
module dsf_flag
    import dsf_pkg::*;
#(
    parameter int OL_BLANK = dsf_pkg::OPEN_LOAD_BLANK_CYC,
    parameter int OFF_TIMEOUT = dsf_pkg::SWITCH_OFF_TIMEOUT_CYC,
    parameter int CLEAR_DELAY = dsf_pkg::FLAG_CLEAR_DELAY_CYC,
    parameter int OV_BLANK = dsf_pkg::OVERVOLTAGE_BLANK_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Host pins
    input wire logic channel_cmd_i,
    input wire logic diag_request_i,
    // Detector levels, asynchronous
    input wire dsf_pkg::dsf_detect_t detect_i,
    // Power stage and status
    output logic power_stage_on_o,
    output logic overtemp_o,
    output logic lockout_o,
    output logic open_load_o,
    // Open-drain fault flag
    output logic fault_flag_out_o,
    output logic fault_flag_out_oe_o
);
    import dsf_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    localparam int NIN = 2 + $bits(dsf_detect_t);
    logic [NIN-1:0] sync_w;
    logic cmd_s;
    logic req_s;
    dsf_detect_t det_s;

    // Command, request and detector levels all pass the same two flops.
    // Limitation: a level shorter than one clock period may be missed.
    dsf_sync #(.W(NIN)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({channel_cmd_i, diag_request_i, detect_i}),
        .q_o(sync_w)
    );

    assign cmd_s = sync_w[NIN-1];
    assign req_s = sync_w[NIN-2];
    assign det_s = dsf_detect_t'(sync_w[NIN-3:0]);

    // ------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------
    logic cmd_q;
    logic cmd_d;
    logic req_q;
    logic req_d;
    logic req_rise;
    logic cmd_fall;

    // Next values of the edge history are the synced levels
    always_comb begin
        cmd_d = cmd_s;
        req_d = req_s;
    end

    // History resets to the idle low level, so no false edge follows reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_q <= 1'b0;
            req_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            req_q <= req_d;
        end
    end

    // A one-cycle request pulse still counts as an edge; no filtering
    assign req_rise = req_s && !req_q;
    assign cmd_fall = !cmd_s && cmd_q;

    // ------------------------------------------------------------
    // Fault qualification
    // ------------------------------------------------------------
    logic ov_done;
    logic overtemp;

    // Overvoltage must persist for the blanking time
    dsf_timer #(.W(CNT_W), .LIMIT(OV_BLANK)) u_ov (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .run_i(det_s.supply_overvoltage),
        .done_o(ov_done)
    ); // RULE11

    // Either temperature source stops the stage; both share one flag
    assign overtemp = det_s.temp_absolute || det_s.temp_gradient; // RULE13

    // ------------------------------------------------------------
    // Limit-set violation with delayed clear
    // ------------------------------------------------------------
    logic [CNT_W-1:0] lim_cnt_q;
    logic [CNT_W-1:0] lim_cnt_d;
    logic lim_flag_q;
    logic lim_flag_d;

    // Flag stays up for the clear delay after the request rises
    // A request that drops early shows the fault again at once
    always_comb begin
        lim_cnt_d = lim_cnt_q;
        lim_flag_d = lim_flag_q;
        if (!cmd_s || !det_s.limit_set_short) begin
            lim_flag_d = 1'b0;
            lim_cnt_d = '0;
        end else if (!req_s) begin
            lim_flag_d = 1'b1; // RULE19 RULE9
            lim_cnt_d = '0;
        end else if (lim_flag_q) begin
            if (lim_cnt_q >= CNT_W'(CLEAR_DELAY - 1)) begin
                lim_flag_d = 1'b0; // RULE10
                lim_cnt_d = '0;
            end else begin
                lim_cnt_d = lim_cnt_q + CNT_W'(1);
            end
        end
    end

    // Limit flag and its clear counter
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lim_cnt_q <= '0;
            lim_flag_q <= 1'b0;
        end else begin
            lim_cnt_q <= lim_cnt_d;
            lim_flag_q <= lim_flag_d;
        end
    end

    // ------------------------------------------------------------
    // Off-state open-load sequencer
    // ------------------------------------------------------------
    dsf_ol_state_t ol_q;
    dsf_ol_state_t ol_d;
    logic [CNT_W-1:0] ol_cnt_q;
    logic [CNT_W-1:0] ol_cnt_d;
    logic off_cond;

    // Comparator sees output near supply, host pull network in use
    assign off_cond = det_s.open_load_condition || det_s.output_short_supply;

    // Timeout after switch-off, then blanking restarted by request edges
    always_comb begin
        ol_d = ol_q;
        ol_cnt_d = ol_cnt_q;
        if (cmd_s) begin
            ol_d = OL_IDLE;
            ol_cnt_d = '0;
        end else if (cmd_fall) begin
            ol_d = OL_TIMEOUT; // RULE6
            ol_cnt_d = '0;
        end else begin
            case (ol_q)
                // Wait for a request edge
                OL_IDLE: begin
                    if (req_rise) begin
                        ol_d = OL_COUNT; // RULE5
                        ol_cnt_d = '0;
                    end
                end
                // Let the output settle after switch-off
                OL_TIMEOUT: begin
                    if (ol_cnt_q >= CNT_W'(OFF_TIMEOUT - 1)) begin
                        ol_d = OL_COUNT; // RULE6
                        ol_cnt_d = '0;
                    end else begin
                        ol_cnt_d = ol_cnt_q + CNT_W'(1);
                    end
                end
                // Condition must hold without a break
                OL_COUNT: begin
                    if (!req_s || !off_cond) begin
                        ol_cnt_d = '0; // RULE4
                        ol_d = req_s ? OL_COUNT : OL_IDLE;
                    end else if (ol_cnt_q >= CNT_W'(OL_BLANK - 1)) begin
                        ol_d = OL_SET; // RULE7
                    end else begin
                        ol_cnt_d = ol_cnt_q + CNT_W'(1);
                    end
                end
                // Report while condition and request last
                OL_SET: begin
                    if (!off_cond) begin
                        ol_d = OL_COUNT; // RULE16
                        ol_cnt_d = '0;
                    end else if (!req_s) begin
                        ol_d = OL_IDLE;
                    end
                end
                default: begin
                    ol_d = OL_IDLE;
                    ol_cnt_d = '0;
                end
            endcase
        end
    end

    // Sequencer state and its shared counter
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ol_q <= OL_IDLE; // RULE18
            ol_cnt_q <= '0;
        end else begin
            ol_q <= ol_d;
            ol_cnt_q <= ol_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Flag and power stage outputs
    // ------------------------------------------------------------
    logic fault_d;
    logic fault_q;
    logic stage_d;
    logic stage_q;
    logic ol_hit;

    logic on_fault;
    logic off_req_fault;
    logic off_fault;

    assign ol_hit = (ol_q == OL_SET) && off_cond && req_s; // RULE8 RULE16

    // Basic faults, watched while the channel is on
    assign on_fault = det_s.ground_short || overtemp || ov_done || lim_flag_q; // RULE2
    // Extended faults need the request
    assign off_req_fault = ov_done || overtemp || ol_hit; // RULE14
    // Lockout is the one fault shown whatever the request
    assign off_fault = ov_done; // RULE3 RULE17

    // Fault mux per channel state
    always_comb begin
        if (cmd_s) begin
            fault_d = on_fault; // RULE2
        end else if (req_s) begin
            fault_d = off_req_fault; // RULE14
        end else begin
            fault_d = off_fault; // RULE3 RULE17
        end
        // Stage restarts by itself once faults clear
        stage_d = cmd_s && !overtemp && !ov_done; // RULE11 RULE12
    end

    // Registered flag keeps mux glitches off the pin
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fault_q <= 1'b0; // RULE18
            stage_q <= 1'b0;
        end else begin
            fault_q <= fault_d;
            stage_q <= stage_d;
        end
    end

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    logic overtemp_q;
    logic overtemp_d;
    logic lockout_q;
    logic lockout_d;
    logic open_load_q;
    logic open_load_d;

    // Status levels change on the same edge as the flag, so the pin
    // and the status outputs that the fault mux selects never disagree for a cycle
    always_comb begin
        overtemp_d = overtemp; // RULE13
        lockout_d = ov_done; // RULE11
        open_load_d = ol_hit; // RULE8
    end

    // Status levels clear together with the flag
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            overtemp_q <= 1'b0; // RULE18
            lockout_q <= 1'b0;
            open_load_q <= 1'b0;
        end else begin
            overtemp_q <= overtemp_d;
            lockout_q <= lockout_d;
            open_load_q <= open_load_d;
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    // Open drain: drive low only on fault, enable low while driving
    assign fault_flag_out_o = 1'b0; // RULE1
    assign fault_flag_out_oe_o = !fault_q; // RULE1
    assign power_stage_on_o = stage_q;
    assign overtemp_o = overtemp_q;
    assign lockout_o = lockout_q;
    assign open_load_o = open_load_q;
endmodule : dsf_flag

// [sim/dsf_host.sv]
// Host side model: pull-up on the open-drain status pin
`timescale 1ns/1ps
module dsf_host (
    // Device pin halves
    input wire logic flag_i,
    input wire logic flag_oe_i,
    // Level the host reads
    output logic pin_o
);
    // A released pin rises through the resistor
    assign pin_o = flag_oe_i ? 1'b1 : flag_i;
endmodule : dsf_host

// [sim/dsf_flag_monitor.sv]
// Port-level checks of the status flag block
`timescale 1ns/1ps
module dsf_flag_monitor
    import dsf_pkg::*;
#(
    parameter int OL_BLANK = 4,
    parameter int OFF_TIMEOUT = 4,
    parameter int OV_BLANK = 4
) (
    // Watched ports
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic channel_cmd_i,
    input wire logic diag_request_i,
    input wire dsf_pkg::dsf_detect_t detect_i,
    input wire logic power_stage_on_o,
    input wire logic overtemp_o,
    input wire logic lockout_o,
    input wire logic open_load_o,
    input wire logic fault_flag_out_o,
    input wire logic fault_flag_out_oe_o
);
    logic [15:0] ol_q, ol_d, off_q, off_d, ov_q, ov_d;
    // ----
    // Raw run lengths; the design lags them, so they are upper bounds on its counts
    // ----
    always_comb begin
        ol_d = (detect_i.open_load_condition | detect_i.output_short_supply) ? ol_q + 16'd1 : '0;
        off_d = channel_cmd_i ? '0 : ((off_q == '1) ? off_q : off_q + 16'd1);
        ov_d = detect_i.supply_overvoltage ? ov_q + 16'd1 : '0;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ol_q <= '0;
            off_q <= '1; // No switch-off precedes reset, so no timeout applies
            ov_q <= '0;
        end else begin
            ol_q <= ol_d;
            off_q <= off_d;
            ov_q <= ov_d;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    data_low_a: assert property (fault_flag_out_o == 1'b0) else $error("flag data high");
    rst_release_a: assert property ($rose(nrst_i) |-> fault_flag_out_oe_o)
        else $error("flag not released at reset exit");
    on_short_a: assert property ((channel_cmd_i && detect_i.ground_short) [*6]
        |-> !fault_flag_out_oe_o) else $error("ground short not flagged");
    off_quiet_a: assert property ((!channel_cmd_i && !diag_request_i && !lockout_o) [*6]
        |-> fault_flag_out_oe_o) else $error("off state flag without lockout");
    ol_blank_a: assert property ($rose(open_load_o) |-> ol_q >= OL_BLANK)
        else $error("open load before blanking");
    ol_timeout_a: assert property ($rose(open_load_o) |-> off_q >= OFF_TIMEOUT + OL_BLANK)
        else $error("open load before switch-off timeout");
    ov_blank_a: assert property ($rose(lockout_o) |-> ov_q >= OV_BLANK)
        else $error("lockout before blanking");
    ov_flag_a: assert property (lockout_o |-> ##[0:2] !fault_flag_out_oe_o)
        else $error("lockout not flagged");
    stage_stop_a: assert property ((overtemp_o || lockout_o) |-> ##[0:2] !power_stage_on_o)
        else $error("stage not stopped");
    ot_src_a: assert property ((detect_i.temp_absolute || detect_i.temp_gradient) [*4]
        |-> overtemp_o) else $error("overtemperature source missed");
    ol_c: cover property ($rose(open_load_o));
    ov_c: cover property ($rose(lockout_o));
    stop_c: cover property ($fell(power_stage_on_o));
endmodule : dsf_flag_monitor

bind dsf_flag dsf_flag_monitor #(.OL_BLANK(OL_BLANK), .OFF_TIMEOUT(OFF_TIMEOUT),
    .OV_BLANK(OV_BLANK)) u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .channel_cmd_i(channel_cmd_i),
    .diag_request_i(diag_request_i), .detect_i(detect_i), .power_stage_on_o(power_stage_on_o),
    .overtemp_o(overtemp_o), .lockout_o(lockout_o), .open_load_o(open_load_o),
    .fault_flag_out_o(fault_flag_out_o), .fault_flag_out_oe_o(fault_flag_out_oe_o));

// [sim/dsf_flag_tb.sv]
// Self-checking bench of the status flag block
`timescale 1ns/1ps
module dsf_flag_tb;
    import dsf_pkg::*;
    localparam int OLB = 8;
    localparam int OFT = 12;
    localparam int CLR = 10;
    localparam int OVB = 6;
    logic clk_i, nrst_i, cmd, req, stage, ot, lock, ol, fd, foe, pin;
    dsf_detect_t det, d;
    int num_errors = 0;
    int n_checks = 0;
    dsf_flag #(.OL_BLANK(OLB), .OFF_TIMEOUT(OFT), .CLEAR_DELAY(CLR), .OV_BLANK(OVB)) DUT (
        .clk_i(clk_i), .nrst_i(nrst_i), .channel_cmd_i(cmd), .diag_request_i(req),
        .detect_i(det), .power_stage_on_o(stage), .overtemp_o(ot), .lockout_o(lock),
        .open_load_o(ol), .fault_flag_out_o(fd), .fault_flag_out_oe_o(foe));
    dsf_host u_host (.flag_i(fd), .flag_oe_i(foe), .pin_o(pin));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ----
    // Tasks
    // ----
    task automatic close_out();
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic drive(input logic c, input logic r, input dsf_detect_t v);
        @(posedge clk_i);
        cmd <= c;
        req <= r;
        det <= v;
    endtask : drive
    task automatic hold(input logic lvl, input int n);
        repeat (n) begin
            @(negedge clk_i);
            chk(pin, lvl);
        end
    endtask : hold
    // Pin must reach lvl no sooner than lo and no later than hi cycles
    task automatic wait_lvl(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (pin !== lvl && n < hi) begin
            @(negedge clk_i);
            n++;
        end
        if (pin !== lvl) begin
            chk(pin, lvl);
            close_out();
        end
        chk(n >= lo, 1'b1);
    endtask : wait_lvl
    initial begin
        nrst_i = 1'b0;
        cmd = 1'b0;
        req = 1'b0;
        det = '0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        hold(1'b1, 2);
        drive(1'b1, 1'b0, '0);
        hold(1'b1, 6);
        // On state: short, both temperature sources, limit current
        for (int b = 6; b >= 0; b--) begin
            if (b == 6 || b == 5 || b == 4 || b == 2) begin
                d = '0;
                d[b] = 1'b1;
                drive(1'b1, 1'b0, d);
                wait_lvl(1'b0, 0, 10);
                hold(1'b0, 2);
                chk(stage, (b == 6 || b == 2));
                chk(ot, (b == 5 || b == 4));
                drive(1'b1, 1'b0, '0);
                wait_lvl(1'b1, 0, 10);
                hold(1'b1, 2);
                chk(stage, 1'b1);
            end
        end
        d = '0;
        d.supply_overvoltage = 1'b1;
        drive(1'b1, 1'b0, d);
        wait_lvl(1'b0, OVB, OVB + 8);
        hold(1'b0, 2);
        chk(stage, 1'b0);
        chk(lock, 1'b1);
        drive(1'b1, 1'b0, '0);
        wait_lvl(1'b1, 0, 10);
        // Limit fault masked by a request, only after the clear delay
        d = '0;
        d.limit_set_short = 1'b1;
        drive(1'b1, 1'b0, d);
        wait_lvl(1'b0, 0, 10);
        drive(1'b1, 1'b1, d);
        hold(1'b0, CLR);
        wait_lvl(1'b1, 0, 10);
        drive(1'b1, 1'b0, d);
        wait_lvl(1'b0, 0, 10);
        drive(1'b1, 1'b0, '0);
        wait_lvl(1'b1, 0, 10);
        // Switch-off with request rising in the same cycle: timeout then blanking
        d = '0;
        d.open_load_condition = 1'b1;
        drive(1'b0, 1'b1, d);
        wait_lvl(1'b0, OFT + OLB, OFT + OLB + 10);
        chk(ol, 1'b1);
        drive(1'b0, 1'b0, d);
        wait_lvl(1'b1, 0, 10);
        hold(1'b1, 12);
        drive(1'b0, 1'b1, d);
        wait_lvl(1'b0, OLB, OLB + 8);
        drive(1'b0, 1'b1, '0);
        wait_lvl(1'b1, 0, 5);
        chk(ol, 1'b0);
        // A gap in the condition restarts the blanking
        drive(1'b0, 1'b0, '0);
        drive(1'b0, 1'b1, d);
        repeat (OLB / 2) @(posedge clk_i);
        drive(1'b0, 1'b1, '0);
        drive(1'b0, 1'b1, d);
        wait_lvl(1'b0, OLB, OLB + 8);
        // Off state: each fault but overvoltage silent without request, some shown with it
        drive(1'b0, 1'b0, '0);
        wait_lvl(1'b1, 0, 10);
        for (int b = 6; b >= 0; b--) begin
            if (b != 3) begin
                d = '0;
                d[b] = 1'b1;
                drive(1'b0, 1'b0, d);
                hold(1'b1, 12);
                if (b == 0 || b == 1 || b == 4 || b == 5) begin
                    drive(1'b0, 1'b1, d);
                    wait_lvl(1'b0, 0, OLB + 8);
                    drive(1'b0, 1'b1, '0);
                    wait_lvl(1'b1, 0, 10);
                end
            end
        end
        d = '0;
        d.supply_overvoltage = 1'b1;
        drive(1'b0, 1'b0, d);
        wait_lvl(1'b0, OVB, OVB + 8);
        chk(lock, 1'b1);
        // Reset in mid-fault releases the pin
        @(posedge clk_i);
        nrst_i <= 1'b0;
        hold(1'b1, 2);
        chk(stage, 1'b0);
        chk(lock, 1'b0);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        drive(1'b0, 1'b0, '0);
        hold(1'b1, 4);
        close_out();
    end
endmodule : dsf_flag_tb
